// ===== hdl/snc_pkg.sv
/*
  Constants for the serial node switch configuration block.
  Assumes a single 125 MHz clock and an AXI4-Lite master for register access.
*/
package snc_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [3:0] SNC_ADDR_CFG = 4'h0;    // Effective address, rate, mode
  localparam logic [3:0] SNC_ADDR_NVM = 4'h4;    // Stored address and rate
  localparam logic [3:0] SNC_ADDR_PDI = 4'h8;    // Input routing mode and live levels
  localparam logic [3:0] SNC_ADDR_SW = 4'hC;     // Raw latched switches
  // ==========================================================
  // Field layout
  localparam int SNC_ADDR_W = 6;
  localparam int SNC_RATE_W = 2;
  localparam int SNC_RATE_LSB = 8;
  localparam int SNC_SEL485_BIT = 16;
  localparam int SNC_MODE_LSB = 0;
  localparam int SNC_PDI_LSB = 4;
  // ==========================================================
  // Bit-rate codes
  localparam logic [1:0] SNC_RATE_NVM = 2'h0;
  localparam logic [1:0] SNC_RATE_9K6 = 2'h1;
  localparam logic [1:0] SNC_RATE_38K4 = 2'h2;
  localparam logic [1:0] SNC_RATE_115K2 = 2'h3;
  localparam int SNC_CLK_HZ = 125000000;
  localparam int SNC_BAUD_9K6 = 9600;
  localparam int SNC_BAUD_38K4 = 38400;
  localparam int SNC_BAUD_115K2 = 115200;
  localparam int SNC_DIV_9K6 = SNC_CLK_HZ / SNC_BAUD_9K6;
  localparam int SNC_DIV_38K4 = SNC_CLK_HZ / SNC_BAUD_38K4;
  localparam int SNC_DIV_115K2 = SNC_CLK_HZ / SNC_BAUD_115K2;
  localparam int SNC_DIV_W = 14;
  // ==========================================================
  // Reset values
  localparam logic [5:0] SNC_NVM_ADDR_RST = 6'h01;
  localparam logic [1:0] SNC_NVM_RATE_RST = 2'h1;
  localparam logic [1:0] SNC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SNC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SNC_PDI_GENERAL, SNC_PDI_STEPDIR, SNC_PDI_AUXENC} snc_pdi_mode_e;
  typedef enum {SNC_LATCH_WAIT, SNC_LATCH_DONE} snc_latch_e;
endpackage

// ===== hdl/snc_switch_config.sv
/*
  Switch-driven RS-485 node configuration with an AXI4-Lite register slave.
  Assumes switch and pin inputs are synchronous to aclk; non-volatile values are
  written by firmware into the stored-value register.
*/
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module snc_switch_config import snc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] switches,
  input wire logic select_rs485_n,
  input wire logic step_or_aux_a_input,
  input wire logic dir_or_aux_b_input,
  input wire logic enc_a_in,
  input wire logic enc_b_in,
  input wire logic enc_i_in,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [5:0] rs485_node_addr,
  output logic [1:0] rs485_rate_code,
  output logic rs485_baud_tick,
  output logic rs485_active,
  output logic general_in5,
  output logic general_in6,
  output logic step_pulse,
  output logic step_dir,
  output logic secondary_encoder_chan_a,
  output logic secondary_encoder_chan_b,
  output logic buffered_chan_a_out,
  output logic buffered_chan_a_out_n,
  output logic buffered_chan_b_out,
  output logic buffered_chan_b_out_n,
  output logic buffered_index_out,
  output logic buffered_index_out_n
);
  // ==========================================================
  // Switch latch, once after reset release
  snc_latch_e latch_reg;
  logic [7:0] sw_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_reg <= SNC_LATCH_WAIT;
      sw_reg <= 8'h00;
    end else begin
      case (latch_reg)
        SNC_LATCH_WAIT: begin
          sw_reg <= switches;
          latch_reg <= SNC_LATCH_DONE;
        end
        SNC_LATCH_DONE: latch_reg <= SNC_LATCH_DONE;
        default: latch_reg <= SNC_LATCH_WAIT;
      endcase
    end
  end
  wire logic [5:0] sw_addr = sw_reg[5:0];
  wire logic [1:0] sw_rate = sw_reg[7:6];

  // ==========================================================
  // Software registers
  logic [5:0] nvm_addr_reg;
  logic [1:0] nvm_rate_reg;
  snc_pdi_mode_e pdi_mode_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  wire logic wr_go = aw_hold_reg && w_hold_reg && !bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= SNC_RESP_OKAY;
      nvm_addr_reg <= SNC_NVM_ADDR_RST;
      nvm_rate_reg <= SNC_NVM_RATE_RST;
      pdi_mode_reg <= SNC_PDI_GENERAL;
    end else begin
      if (awvalid && awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
        wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= SNC_RESP_OKAY;
        case (aw_addr_reg)
          SNC_ADDR_NVM: begin
            if (w_strb_reg[0]) nvm_addr_reg <= w_data_reg[SNC_ADDR_W-1:0];
            if (w_strb_reg[1]) nvm_rate_reg <= w_data_reg[SNC_RATE_LSB +: SNC_RATE_W];
          end
          SNC_ADDR_PDI: begin
            if (w_strb_reg[0]) begin
              case (w_data_reg[1:0])
                2'h1: pdi_mode_reg <= SNC_PDI_STEPDIR;
                2'h2: pdi_mode_reg <= SNC_PDI_AUXENC;
                default: pdi_mode_reg <= SNC_PDI_GENERAL;
              endcase
            end
          end
          SNC_ADDR_CFG, SNC_ADDR_SW: bresp <= SNC_RESP_SLVERR;
          default: bresp <= SNC_RESP_SLVERR;
        endcase
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Effective RS-485 settings
  logic [5:0] eff_addr;
  logic [1:0] eff_rate;
  always_comb begin
    eff_addr = (sw_addr == 6'h00) ? nvm_addr_reg : sw_addr;
    eff_rate = (sw_rate == SNC_RATE_NVM) ? nvm_rate_reg : sw_rate;
  end

  // Read side: one cycle to rvalid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= SNC_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= SNC_RESP_OKAY;
      rdata <= 32'h0000_0000;
      case (araddr)
        SNC_ADDR_CFG: begin
          rdata[SNC_ADDR_W-1:0] <= eff_addr;
          rdata[SNC_RATE_LSB +: SNC_RATE_W] <= eff_rate;
          rdata[SNC_SEL485_BIT] <= !select_rs485_n;
        end
        SNC_ADDR_NVM: begin
          rdata[SNC_ADDR_W-1:0] <= nvm_addr_reg;
          rdata[SNC_RATE_LSB +: SNC_RATE_W] <= nvm_rate_reg;
        end
        SNC_ADDR_PDI: begin
          rdata[SNC_MODE_LSB +: 2] <= pdi_mode_reg;
          rdata[SNC_PDI_LSB +: 2] <= {dir_or_aux_b_input, step_or_aux_a_input};
        end
        SNC_ADDR_SW: rdata[7:0] <= sw_reg;
        default: rresp <= SNC_RESP_SLVERR;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ==========================================================
  // Bit-rate divider; RS-232 mode stops the tick and zeroes the address and rate outputs
  logic [SNC_DIV_W-1:0] div_cnt_reg;
  logic [SNC_DIV_W-1:0] div_top;
  always_comb begin
    case (eff_rate)
      SNC_RATE_38K4: div_top = SNC_DIV_W'(SNC_DIV_38K4 - 1);
      SNC_RATE_115K2: div_top = SNC_DIV_W'(SNC_DIV_115K2 - 1);
      default: div_top = SNC_DIV_W'(SNC_DIV_9K6 - 1);
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_reg <= '0;
      rs485_baud_tick <= 1'b0;
      rs485_node_addr <= 6'h00;
      rs485_rate_code <= 2'h0;
      rs485_active <= 1'b0;
    end else begin
      rs485_active <= !select_rs485_n;
      // Settings are only published in RS-485 mode
      rs485_node_addr <= select_rs485_n ? 6'h00 : eff_addr;
      rs485_rate_code <= select_rs485_n ? 2'h0 : eff_rate;
      // A stored rate of zero is treated as the slowest rate
      if (select_rs485_n || div_cnt_reg >= div_top) begin
        div_cnt_reg <= '0;
        rs485_baud_tick <= !select_rs485_n;
      end else begin
        div_cnt_reg <= div_cnt_reg + 1'b1;
        rs485_baud_tick <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Input five/six routing and buffered encoder copies
  logic step_d_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_d_reg <= 1'b0;
      general_in5 <= 1'b0;
      general_in6 <= 1'b0;
      step_pulse <= 1'b0;
      step_dir <= 1'b0;
      secondary_encoder_chan_a <= 1'b0;
      secondary_encoder_chan_b <= 1'b0;
    end else begin
      step_d_reg <= step_or_aux_a_input;
      general_in5 <= (pdi_mode_reg == SNC_PDI_GENERAL) && step_or_aux_a_input;
      general_in6 <= (pdi_mode_reg == SNC_PDI_GENERAL) && dir_or_aux_b_input;
      step_pulse <= (pdi_mode_reg == SNC_PDI_STEPDIR) && step_or_aux_a_input && !step_d_reg;
      step_dir <= (pdi_mode_reg == SNC_PDI_STEPDIR) && dir_or_aux_b_input;
      secondary_encoder_chan_a <= (pdi_mode_reg == SNC_PDI_AUXENC) && step_or_aux_a_input;
      secondary_encoder_chan_b <= (pdi_mode_reg == SNC_PDI_AUXENC) && dir_or_aux_b_input;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buffered_chan_a_out <= 1'b0;
      buffered_chan_a_out_n <= 1'b1;
      buffered_chan_b_out <= 1'b0;
      buffered_chan_b_out_n <= 1'b1;
      buffered_index_out <= 1'b0;
      buffered_index_out_n <= 1'b1;
    end else begin
      buffered_chan_a_out <= enc_a_in;
      buffered_chan_a_out_n <= !enc_a_in;
      buffered_chan_b_out <= enc_b_in;
      buffered_chan_b_out_n <= !enc_b_in;
      buffered_index_out <= enc_i_in;
      buffered_index_out_n <= !enc_i_in;
    end
  end

  // ==========================================================
  // Checks
  sequence s_latched;
    $past(latch_reg) == SNC_LATCH_DONE;
  endsequence
  AST_SW_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_latched |-> $stable(sw_reg)) else $error("switch latch changed after capture");
  AST_ADDR_MAP: assert property (@(posedge aclk) disable iff (!aresetn)
    (!select_rs485_n && sw_addr != 6'h00) |=> rs485_node_addr == $past(sw_reg[5:0]))
    else $error("node address not from switches");
  AST_RATE_MAP: assert property (@(posedge aclk) disable iff (!aresetn)
    (!select_rs485_n && sw_rate != 2'h0) |=> rs485_rate_code == $past(sw_reg[7:6]))
    else $error("rate code not from switches");
  AST_NVM_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
    (!select_rs485_n && sw_addr == 6'h00) |=> rs485_node_addr == $past(nvm_addr_reg))
    else $error("stored address not used");
  AST_RS232: assert property (@(posedge aclk) disable iff (!aresetn)
    select_rs485_n |=> (rs485_node_addr == 6'h00 && !rs485_baud_tick))
    else $error("switches leaked into RS-232 mode");
  AST_DIV: assert property (@(posedge aclk) disable iff (!aresetn)
    (!select_rs485_n && div_cnt_reg == 0 && rs485_rate_code == SNC_RATE_115K2
     && $stable(rs485_rate_code)) |-> div_top == SNC_DIV_W'(SNC_DIV_115K2 - 1))
    else $error("wrong divider for fastest rate");
  AST_PDI: assert property (@(posedge aclk) disable iff (!aresetn)
    (pdi_mode_reg != SNC_PDI_GENERAL) |=> !general_in5 && !general_in6)
    else $error("general input active in special mode");
  AST_ENC: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> buffered_chan_a_out == $past(enc_a_in) && buffered_chan_a_out_n != buffered_chan_a_out)
    else $error("encoder copy wrong");
endmodule // snc_switch_config

// ===== tb/snc_host_model.sv
/*
  Host side of the RS-485 link: grounds or opens the select pin, measures ticks.
  Assumes one clock shared with the block.
*/
`timescale 1ns/1ps
module snc_host_model (
  input wire logic aclk,
  input wire logic want_rs485,
  input wire logic rs485_baud_tick,
  output logic select_rs485_n,
  output int tick_period,
  output int tick_count
);
  int cnt = 0;
  int per = 0;
  int num = 0;
  // Pin tied to ground picks RS-485, left open it floats high for RS-232
  assign select_rs485_n = !want_rs485;
  assign tick_period = per;
  assign tick_count = num;
  always @(posedge aclk) begin
    cnt <= rs485_baud_tick ? 1 : cnt + 1;
    if (rs485_baud_tick) begin
      per <= cnt;
      num <= num + 1;
    end
  end
endmodule // snc_host_model

// ===== tb/snc_switch_config_tb.sv
/*
  Self-checking bench for the switch configuration block.
  Assumes the AXI4-Lite slave answers each request well within the watchdog span.
*/
`timescale 1ns/1ps
module snc_switch_config_tb import snc_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] switches = 8'h00;
  logic step_in = 1'b0, dir_in = 1'b0, want_rs485 = 1'b1;
  logic [2:0] enc = 3'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, d;
  logic awready, wready, bvalid, arready, rvalid, tick, act, sel_n;
  logic [1:0] bresp, rresp, rate, r;
  logic [5:0] node;
  logic g5, g6, sp, sdir, sa, sb, ba, ban, bb, bbn, bi, bin;
  int tick_period, tick_count, bad_count = 0, samples_checked = 0;
  always #4 aclk = ~aclk;
  snc_switch_config snc_switch_config_i (.aclk(aclk), .aresetn(aresetn), .switches(switches),
    .select_rs485_n(sel_n), .step_or_aux_a_input(step_in), .dir_or_aux_b_input(dir_in),
    .enc_a_in(enc[2]), .enc_b_in(enc[1]), .enc_i_in(enc[0]), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rs485_node_addr(node), .rs485_rate_code(rate), .rs485_baud_tick(tick),
    .rs485_active(act), .general_in5(g5), .general_in6(g6), .step_pulse(sp), .step_dir(sdir),
    .secondary_encoder_chan_a(sa), .secondary_encoder_chan_b(sb),
    .buffered_chan_a_out(ba), .buffered_chan_a_out_n(ban), .buffered_chan_b_out(bb),
    .buffered_chan_b_out_n(bbn), .buffered_index_out(bi), .buffered_index_out_n(bin));
  snc_host_model snc_host_model_i (.aclk(aclk), .want_rs485(want_rs485),
    .rs485_baud_tick(tick), .select_rs485_n(sel_n), .tick_period(tick_period),
    .tick_count(tick_count));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic do_reset(input logic [7:0] sw);
    @(posedge aclk);
    aresetn <= 1'b0;
    switches <= sw;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_rates();
    int start;
    for (int c = 1; c < 4; c++) begin
      do_reset({c[1:0], 6'h2B});
      chk(node, 32'h2B);
      chk(rate, c);
      start = tick_count;
      for (int n = 0; n < 30000 && tick_count < start + 2; n++) @(posedge aclk);
      chk(tick_period, c == 1 ? SNC_DIV_9K6 : c == 2 ? SNC_DIV_38K4 : SNC_DIV_115K2);
    end
    // Later switch moves are ignored until the next reset
    switches <= 8'h00;
    repeat (5) @(posedge aclk);
    chk(node, 32'h2B);
    axi_rd(SNC_ADDR_SW);
    chk(d, 32'hEB);
    axi_rd(SNC_ADDR_CFG);
    chk(d, 32'h0001032B);
  endtask
  task automatic t_nvm();
    do_reset(8'h00);
    chk({rate, node}, {SNC_NVM_RATE_RST, SNC_NVM_ADDR_RST});
    axi_wr(SNC_ADDR_NVM, 32'h00000315);
    chk(r, SNC_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk({rate, node}, 32'hD5);
    axi_wr(SNC_ADDR_CFG, 32'h0);
    chk(r, SNC_RESP_SLVERR);
  endtask
  task automatic t_rs232();
    int start;
    do_reset(8'hC7);
    want_rs485 <= 1'b0;
    repeat (4) @(posedge aclk);
    start = tick_count;
    chk({act, rate, node}, 32'h0);
    repeat (1200) @(posedge aclk);
    chk(tick_count - start, 32'h0);
    want_rs485 <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({act, rate, node}, 32'h1C7);
  endtask
  task automatic t_pdi();
    int mm;
    // Mode code 3 is not a routing choice and falls back to general inputs
    for (int m = 0; m < 4; m++) begin
      mm = (m == 3) ? 0 : m;
      axi_wr(SNC_ADDR_PDI, m);
      step_in <= 1'b1;
      dir_in <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(sp, mm == 1);
      @(posedge aclk);
      chk(sp, 1'b0);
      chk({g5, g6, sdir, sa, sb}, {mm == 0, mm == 0, mm == 1, mm == 2, mm == 2});
      axi_rd(SNC_ADDR_PDI);
      chk(d, 32'h30 | mm);
      step_in <= 1'b0;
      dir_in <= 1'b0;
    end
  endtask
  task automatic t_enc();
    for (int v = 0; v < 8; v++) begin
      enc <= v[2:0];
      repeat (3) @(posedge aclk);
      chk({ba, bb, bi, ban, bbn, bin}, {v[2:0], ~v[2:0]});
    end
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    t_rates();
    t_nvm();
    t_rs232();
    t_pdi();
    t_enc();
    final_report();
  end
  initial begin
    repeat (90000) @(posedge aclk);
    bad_count++;
    final_report();
  end
endmodule // snc_switch_config_tb
